/* File: tws_pkg.sv */
// Purpose: Shared constants and types of the two-wire slave receiver.
// Assumes: A 50 MHz system clock on both ends.
// Notes: Status codes carry zero in their low three bits.
package tws_pkg;
   localparam logic [1:0] OFS_OAR = 2'h0;
   localparam logic [1:0] OFS_CTL = 2'h1;
   localparam logic [1:0] OFS_STS = 2'h2;
   localparam logic [1:0] OFS_DAT = 2'h3;
   localparam int CTL_FLAG = 7;
   localparam int CTL_ACK = 6;
   localparam int CTL_STA = 5;
   localparam int CTL_STO = 4;
   localparam int CTL_WC = 3;
   localparam int CTL_EN = 2;
   localparam int CTL_IE = 0;
   localparam int OAR_GCE = 0;
   localparam logic [7:0] OAR_RST = 8'h00;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] DAT_RST = 8'hFF;
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam logic [7:0] STS_MASK = 8'hF8;
   localparam logic [7:0] ST_SLA_ACK = 8'h60;
   localparam logic [7:0] ST_ARB_SLA = 8'h68;
   localparam logic [7:0] ST_GC_ACK = 8'h70;
   localparam logic [7:0] ST_ARB_GC = 8'h78;
   localparam logic [7:0] ST_DAT_ACK = 8'h80;
   localparam logic [7:0] ST_DAT_NACK = 8'h88;
   localparam logic [7:0] ST_GD_ACK = 8'h90;
   localparam logic [7:0] ST_GD_NACK = 8'h98;
   localparam logic [7:0] ST_STOP = 8'hA0;
   localparam logic [7:0] ST_NONE = 8'hF8;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int SYS_NS = 20;
   localparam int LINK_HALF_NS = 80;
   localparam int HALF_CYC = (LINK_HALF_NS + SYS_NS - 1) / SYS_NS;
   typedef enum logic [1:0]
   {
      TWS_CMD_START = 2'b00,
      TWS_CMD_WRITE = 2'b01,
      TWS_CMD_STOP = 2'b10
   } tws_cmd_t;
   typedef enum logic [2:0]
   {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_AACK = 3'b010,
      D_DATA = 3'b011,
      D_DACK = 3'b100
   } tws_dst_t;
   typedef enum logic [2:0]
   {
      H_IDLE = 3'b000,
      H_RS = 3'b001,
      H_ST = 3'b010,
      H_LOW = 3'b011,
      H_HIGH = 3'b100,
      H_P1 = 3'b101,
      H_P2 = 3'b110,
      H_P3 = 3'b111
   } tws_hst_t;
endpackage : tws_pkg

/* File: tws_if.sv */
// Purpose: Open-drain clock and data wires between master and slave.
// Assumes: Each party pulls a wire low while its enable is high.
// Notes: Wire levels are resolved here from the enables.
`timescale 1ns/1ps
interface tws_if;
   logic m_scl_oe;
   logic m_sda_oe;
   logic s_scl_oe;
   logic s_sda_oe;
   logic scl;
   logic sda;
   assign scl = ~(m_scl_oe | s_scl_oe);
   assign sda = ~(m_sda_oe | s_sda_oe);
   modport dev (input scl, input sda, output s_scl_oe, output s_sda_oe);
   modport mst (input scl, input sda, output m_scl_oe, output m_sda_oe);
endinterface : tws_if

/* File: tws_master_tx.sv */
// Purpose: Bus master transmitter that drives the slave receiver.
// Assumes: Commands are given only while o_ready is high.
// Notes: The link clock is made by dividing the system clock.
`timescale 1ns/1ps
module tws_master_tx import tws_pkg::*;
#(
   parameter int HALF = HALF_CYC
)
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_cmd_valid,
   input wire tws_cmd_t i_cmd,
   input wire logic [7:0] i_cmd_byte,
   output logic o_ready,
   output logic o_done,
   output logic o_nack,
   tws_if.mst bus
);
   typedef struct packed
   {
      logic [1:0] scl_q;
      logic [1:0] sda_q;
      tws_hst_t st;
      logic [7:0] cnt;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic scl_oe;
      logic sda_oe;
      logic held;
      logic ready;
      logic done;
      logic nack;
   } tws_mst_s_t;

   localparam logic [7:0] LAST = 8'(HALF - 1);
   tws_mst_s_t r;
   tws_mst_s_t n;
   logic scl_s;
   logic sda_s;
   logic last;

   always_comb
   begin
      n = r;
      n.scl_q = {r.scl_q[0], bus.scl};
      n.sda_q = {r.sda_q[0], bus.sda};
      scl_s = r.scl_q[1];
      sda_s = r.sda_q[1];
      last = (r.cnt == LAST);
      n.cnt = r.cnt + 8'h01;
      n.done = 1'b0;
      case (r.st)
         H_IDLE:
         begin
            n.cnt = 8'h00;
            if (i_cmd_valid && r.ready)
            begin
               n.sh = i_cmd_byte;
               n.bitc = 4'h0;
               if (i_cmd == TWS_CMD_START)
               begin
                  n.scl_oe = 1'b0;
                  n.st = H_RS;
               end
               else if (i_cmd == TWS_CMD_WRITE)
                  n.st = H_LOW;
               else
                  n.st = H_P1;
            end
         end
         H_RS:
         begin
            n.sda_oe = 1'b0;
            if (!scl_s)
               n.cnt = 8'h00;
            else if (last)
            begin
               n.sda_oe = 1'b1;
               n.cnt = 8'h00;
               n.st = H_ST;
            end
         end
         H_ST:
         begin
            if (last)
            begin
               n.scl_oe = 1'b1;
               n.cnt = 8'h00;
               n.st = H_LOW;
            end
         end
         H_LOW:
         begin
            n.scl_oe = 1'b1;
            if (r.cnt == 8'h01)
               n.sda_oe = (r.bitc < BYTE_BITS) ? ~r.sh[7] : 1'b0;
            if (last)
            begin
               n.scl_oe = 1'b0;
               n.cnt = 8'h00;
               n.st = H_HIGH;
            end
         end
         H_HIGH:
         begin
            if (!scl_s)
               n.cnt = 8'h00;
            else if (last)
            begin
               n.scl_oe = 1'b1;
               n.cnt = 8'h00;
               if (r.bitc == BYTE_BITS)
               begin
                  n.nack = sda_s;
                  n.done = 1'b1;
                  n.held = 1'b1;
                  n.st = H_IDLE;
               end
               else
               begin
                  n.bitc = r.bitc + 4'h1;
                  n.sh = {r.sh[6:0], 1'b0};
                  n.st = H_LOW;
               end
            end
         end
         H_P1:
         begin
            n.scl_oe = 1'b1;
            if (r.cnt == 8'h01)
               n.sda_oe = 1'b1;
            if (last)
            begin
               n.scl_oe = 1'b0;
               n.cnt = 8'h00;
               n.st = H_P2;
            end
         end
         H_P2:
         begin
            if (!scl_s)
               n.cnt = 8'h00;
            else if (last)
            begin
               n.sda_oe = 1'b0;
               n.cnt = 8'h00;
               n.st = H_P3;
            end
         end
         default:
         begin
            if (last)
            begin
               n.held = 1'b0;
               n.done = 1'b1;
               n.st = H_IDLE;
            end
         end
      endcase
      n.ready = (n.st == H_IDLE);
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         r <= '{scl_q: 2'h3, sda_q: 2'h3, st: H_IDLE, default: '0};
      else
         r <= n;
   end

   assign o_ready = r.ready;
   assign o_done = r.done;
   assign o_nack = r.nack;
   assign bus.m_scl_oe = r.scl_oe;
   assign bus.m_sda_oe = r.sda_oe;
endmodule : tws_master_tx

/* File: tws_slave_rx.sv */
// Purpose: Slave receiver end of a byte-oriented two-wire interface.
// Assumes: Software reaches the registers over a plain strobe port.
// Notes: Both bus wires are synchronised before any logic reads them.
//
// Summary of operation
// - Upper seven address bits are own address.
// - Address bit zero enables general call answer.
// - Software sets interface enable to operate.
// - Software sets ack enable, clears start, stop.
// - Write direction enters receive; read is not.
// - Own address plus write sets event flag.
// - After lost arbitration report 68 or 78.
// - Cleared ack enable gives NACK next byte.
// - Ack enable low ignores address; resumes later.
// - Address match in sleep still acknowledged, wakes.
// - Hold clock low until flag cleared.
// - Data register not loaded during sleep.
// - Own address acknowledged reports status 60.
// - Lost arbitration, own address reports 68.
// - General call acknowledged reports status 70.
// - Lost arbitration, general call reports 78.
// - Acknowledged own data byte reports 80.
// - NACKed own data reports 88, unaddressed.
// - General call needs its enable bit set.
// - Start request issues START once bus free.
// - Status read with prescaler bits zero.
// - General call data reports 90 or 98.
// - STOP or restart while addressed reports A0.
`timescale 1ns/1ps
module tws_slave_rx import tws_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_sleep,
   input wire logic i_arb_lost,
   output logic o_wake,
   output logic o_start_go,
   output logic o_event,
   tws_if.dev bus
);
   typedef struct packed
   {
      logic [2:0] scl_q;
      logic [2:0] sda_q;
      tws_dst_t st;
      logic [7:0] oar;
      logic ack_en;
      logic start_req_col;
      logic stop_req_col;
      logic wc;
      logic en;
      logic ie;
      logic flag;
      logic [7:0] status;
      logic [7:0] data;
      logic [7:0] sh;
      logic [3:0] bitc;
      logic gc;
      logic arb;
      logic ack;
      logic busy;
      logic hold;
      logic sda_oe;
      logic scl_oe;
      logic wake;
      logic start_go;
      logic evt;
      logic [7:0] rdata;
   } tws_dev_s_t;

   tws_dev_s_t r;
   tws_dev_s_t n;
   logic scl_hi;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   logic own_m;
   logic gc_m;

   always_comb
   begin
      n = r;
      n.scl_q = {r.scl_q[1:0], bus.scl};
      n.sda_q = {r.sda_q[1:0], bus.sda};
      scl_hi = r.scl_q[1] & r.scl_q[2];
      rise = r.scl_q[1] & ~r.scl_q[2];
      fall = ~r.scl_q[1] & r.scl_q[2];
      start_c = scl_hi & r.sda_q[2] & ~r.sda_q[1];
      stop_c = scl_hi & ~r.sda_q[2] & r.sda_q[1];
      own_m = (r.sh[7:1] == r.oar[7:1]) && !r.sh[0];
      gc_m = (r.sh == GC_ADDR) && r.oar[OAR_GCE];
      n.start_go = 1'b0;
      n.rdata = 8'h00;
      // Software accesses come first so that hardware events win.
      if (i_wr)
      begin
         if (i_addr == OFS_OAR)
            n.oar = i_wdata;
         else if (i_addr == OFS_CTL)
         begin
            n.ack_en = i_wdata[CTL_ACK];
            n.start_req_col = i_wdata[CTL_STA];
            n.stop_req_col = i_wdata[CTL_STO];
            n.en = i_wdata[CTL_EN];
            n.ie = i_wdata[CTL_IE];
            if (i_wdata[CTL_FLAG])
               n.flag = 1'b0;
         end
         else if (i_addr == OFS_DAT)
         begin
            if (r.flag)
            begin
               n.data = i_wdata;
               n.wc = 1'b0;
            end
            else
               n.wc = 1'b1;
         end
      end
      if (i_rd)
      begin
         if (i_addr == OFS_OAR)
            n.rdata = r.oar;
         else if (i_addr == OFS_CTL)
            n.rdata = {r.flag, r.ack_en, r.start_req_col, r.stop_req_col, r.wc, r.en, 1'b0,
               r.ie};
         else if (i_addr == OFS_STS)
            n.rdata = r.status & STS_MASK;
         else
            n.rdata = r.data;
      end
      if (!i_sleep)
         n.wake = 1'b0;
      if (start_c)
         n.busy = 1'b1;
      else if (stop_c)
         n.busy = 1'b0;
      if (!r.en)
      begin
         n.st = D_IDLE;
         n.sda_oe = 1'b0;
         n.hold = 1'b0;
      end
      else if (start_c || stop_c)
      begin
         if (r.st == D_DATA || r.st == D_DACK)
         begin
            n.status = ST_STOP;
            n.flag = 1'b1;
            n.hold = 1'b0;
         end
         n.sda_oe = 1'b0;
         n.bitc = 4'h0;
         n.st = start_c ? D_ADDR : D_IDLE;
      end
      else
      begin
         case (r.st)
            D_ADDR:
            begin
               if (rise)
               begin
                  n.sh = {r.sh[6:0], r.sda_q[1]};
                  n.bitc = r.bitc + 4'h1;
               end
               else if (fall && r.bitc == BYTE_BITS)
               begin
                  if (r.ack_en && (own_m || gc_m))
                  begin
                     n.sda_oe = 1'b1;
                     n.gc = ~own_m;
                     n.arb = i_arb_lost;
                     n.wake = i_sleep;
                     n.st = D_AACK;
                  end
                  else
                     n.st = D_IDLE;
               end
            end
            D_AACK:
            begin
               if (fall)
               begin
                  n.sda_oe = 1'b0;
                  n.flag = 1'b1;
                  n.hold = 1'b1;
                  if (r.gc)
                     n.status = r.arb ? ST_ARB_GC : ST_GC_ACK;
                  else
                     n.status = r.arb ? ST_ARB_SLA : ST_SLA_ACK;
                  n.bitc = 4'h0;
                  n.st = D_DATA;
               end
            end
            D_DATA:
            begin
               if (rise)
               begin
                  n.sh = {r.sh[6:0], r.sda_q[1]};
                  n.bitc = r.bitc + 4'h1;
               end
               else if (fall && r.bitc == BYTE_BITS)
               begin
                  n.ack = r.ack_en;
                  n.sda_oe = r.ack_en;
                  if (!i_sleep)
                     n.data = r.sh;
                  n.st = D_DACK;
               end
            end
            D_DACK:
            begin
               if (fall)
               begin
                  n.sda_oe = 1'b0;
                  n.flag = 1'b1;
                  n.hold = 1'b1;
                  if (r.gc)
                     n.status = r.ack ? ST_GD_ACK : ST_GD_NACK;
                  else
                     n.status = r.ack ? ST_DAT_ACK : ST_DAT_NACK;
                  n.bitc = 4'h0;
                  n.st = r.ack ? D_DATA : D_IDLE;
               end
            end
            default:
            begin
               n.sda_oe = 1'b0;
            end
         endcase
      end
      if (r.start_req_col && !r.busy && !r.flag && r.st == D_IDLE)
      begin
         n.start_go = 1'b1;
         n.start_req_col = 1'b0;
      end
      n.scl_oe = n.flag & n.hold & n.en;
      n.evt = n.flag & n.ie;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         r <= '{scl_q: 3'h7, sda_q: 3'h7, st: D_IDLE, oar: OAR_RST,
            ack_en: CTL_RST[CTL_ACK], en: CTL_RST[CTL_EN],
            status: ST_NONE, data: DAT_RST, default: '0};
      else
         r <= n;
   end

   assign o_rdata = r.rdata;
   assign o_wake = r.wake;
   assign o_start_go = r.start_go;
   assign o_event = r.evt;
   assign bus.s_scl_oe = r.scl_oe;
   assign bus.s_sda_oe = r.sda_oe;
endmodule : tws_slave_rx

/* File: tws_assertions.sv */
// Purpose: Concurrent checks on the wires between master and slave.
// Assumes: Master half period of 4 system clocks.
// Notes: Event output is watched with the interrupt enable kept on.
`timescale 1ns/1ps
module tws_assertions
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic s_scl_oe,
   input wire logic s_sda_oe,
   input wire logic scl,
   input wire logic sda,
   input wire logic o_event,
   input wire logic o_wake,
   input wire logic o_start_go,
   input wire logic i_sleep
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);

   // The stretch with a raised flag follows within a few cycles.
   sequence s_stretch;
      ##[0:4] (s_scl_oe && o_event);
   endsequence

   property p_sda_steady;
      scl && $past(scl) |-> $stable(s_sda_oe);
   endproperty
   a_sda_steady: assert property (p_sda_steady)
      else $error("Slave data line moved while the clock was high.");

   property p_ack_low;
      $rose(s_sda_oe) |-> !scl;
   endproperty
   a_ack_low: assert property (p_ack_low)
      else $error("Acknowledge started outside the clock low phase.");

   property p_rel_low;
      $fell(s_sda_oe) |-> !scl;
   endproperty
   a_rel_low: assert property (p_rel_low)
      else $error("Acknowledge released outside the clock low phase.");

   property p_ack_stretch;
      $fell(s_sda_oe) |-> s_stretch;
   endproperty
   a_ack_stretch: assert property (p_ack_stretch)
      else $error("No clock stretch with event after an acknowledge.");

   property p_flag_stretch;
      $rose(s_scl_oe) |-> ##[0:1] o_event;
   endproperty
   a_flag_stretch: assert property (p_flag_stretch)
      else $error("Clock stretched without an event flag.");

   property p_hold;
      $fell(s_scl_oe) |-> ##[0:1] !o_event;
   endproperty
   a_hold: assert property (p_hold)
      else $error("Clock released while the event flag stayed set.");

   property p_wake_set;
      $rose(o_wake) |-> $past(i_sleep);
   endproperty
   a_wake_set: assert property (p_wake_set)
      else $error("Wake raised outside sleep.");

   property p_wake_clr;
      !i_sleep && !$past(i_sleep) |-> !o_wake;
   endproperty
   a_wake_clr: assert property (p_wake_clr)
      else $error("Wake stayed high after sleep ended.");

   property p_start_pulse;
      o_start_go |=> !o_start_go;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("Start pulse longer than one cycle.");

   property p_start_free;
      o_start_go |-> scl && sda;
   endproperty
   a_start_free: assert property (p_start_free)
      else $error("Start served while the bus was busy.");
endmodule : tws_assertions

/* File: two_wire_slave_receiver_test.sv */
// Purpose: Self-checking bench for the master and slave pair.
// Assumes: Both ends share one system clock and one interface.
// Notes: Expected values are queued and compared by a monitor.
`timescale 1ns/1ps
module two_wire_slave_receiver_test import tws_pkg::*;;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0, rd = 1'b0, sleep = 1'b0, arb = 1'b0, cv = 1'b0;
   tws_cmd_t cmd = TWS_CMD_STOP;
   logic [7:0] cbyte = 8'h00;
   logic [7:0] rdata;
   logic wake, start_go, event_o, ready, done, nack;
   logic rd_d = 1'b0, done_d = 1'b0, sg_seen = 1'b0;
   logic [7:0] exp_rd[$];
   logic exp_ack[$];
   int mismatches = 0, tests_run = 0, cycles = 0;
   logic [31:0] seed = 32'hD639E0F1;
   logic [6:0] own;
   logic gce, ctl_ack;
   tws_if bus_if();

   tws_master_tx #(.HALF(4)) tws_master_tx_i(.i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn), .i_cmd_valid(cv), .i_cmd(cmd), .i_cmd_byte(cbyte),
      .o_ready(ready), .o_done(done), .o_nack(nack), .bus(bus_if.mst));
   tws_slave_rx tws_slave_rx_i(.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_sleep(sleep), .i_arb_lost(arb), .o_wake(wake),
      .o_start_go(start_go), .o_event(event_o), .bus(bus_if.dev));
   tws_assertions tws_assertions_i(.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .s_scl_oe(bus_if.s_scl_oe), .s_sda_oe(bus_if.s_sda_oe),
      .scl(bus_if.scl), .sda(bus_if.sda), .o_event(event_o), .o_wake(wake),
      .o_start_go(start_go), .i_sleep(sleep));

   always #10 i_clk_sys = ~i_clk_sys;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         mismatches++;
      end
   endtask : chk

   task automatic summarize;
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   // Polls at the falling edge: 0 ready, 1 done, 2 event, 3 start.
   task automatic wait_hi(input int sel);
      int n;
      logic s;
      n = 0;
      s = 1'b0;
      while (s !== 1'b1 && n < 2000)
      begin
         @(negedge i_clk_sys);
         n++;
         s = sel == 0 ? ready : sel == 1 ? done : sel == 2 ? event_o : sg_seen;
      end
      if (s !== 1'b1)
         chk(8'h01, 8'h00);
   endtask : wait_hi

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk_sys);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
      exp_rd.push_back(e);
      @(posedge i_clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk_sys);
      rd <= 1'b0;
   endtask : rd_reg

   task automatic send(input tws_cmd_t c, input logic [7:0] b, input logic n);
      if (c != TWS_CMD_STOP)
         exp_ack.push_back(n);
      wait_hi(0);
      @(posedge i_clk_sys);
      cmd <= c;
      cbyte <= b;
      cv <= 1'b1;
      @(posedge i_clk_sys);
      cv <= 1'b0;
      wait_hi(1);
   endtask : send

   task automatic frame(input logic [7:0] ab, input logic al, input logic ea,
      input logic slp);
      logic gc, hit;
      logic [7:0] d;
      gc = (ab == GC_ADDR);
      hit = ctl_ack && (gc ? gce : (ab == {own, 1'b0}));
      seed = xs(seed);
      d = seed[7:0];
      @(posedge i_clk_sys);
      arb <= al;
      sleep <= slp;
      send(TWS_CMD_START, ab, !hit);
      if (hit)
      begin
         wait_hi(2);
         chk({7'h00, wake}, {7'h00, slp});
         @(posedge i_clk_sys);
         sleep <= 1'b0;
         rd_reg(OFS_STS, gc ? (al ? ST_ARB_GC : ST_GC_ACK)
            : (al ? ST_ARB_SLA : ST_SLA_ACK));
         wr_reg(OFS_CTL, ea ? 8'hC5 : 8'h85);
         send(TWS_CMD_WRITE, d, !ea);
         wait_hi(2);
         rd_reg(OFS_STS, gc ? (ea ? ST_GD_ACK : ST_GD_NACK)
            : (ea ? ST_DAT_ACK : ST_DAT_NACK));
         rd_reg(OFS_DAT, d);
         wr_reg(OFS_CTL, ea ? 8'hC5 : 8'hE5);
         sg_seen = 1'b0;
         send(TWS_CMD_STOP, 8'h00, 1'b0);
         wait_hi(ea ? 2 : 3);
         if (ea)
            rd_reg(OFS_STS, ST_STOP);
         wr_reg(OFS_CTL, 8'hC5);
      end
      else
         send(TWS_CMD_STOP, 8'h00, 1'b0);
   endtask : frame

   always @(posedge i_clk_sys)
   begin
      if (rd_d)
         chk(rdata, exp_rd.pop_front());
      if (done_d && cmd != TWS_CMD_STOP && exp_ack.size() > 0)
         chk({7'h00, nack}, {7'h00, exp_ack.pop_front()});
      if (start_go === 1'b1)
         sg_seen = 1'b1;
      rd_d <= rd;
      done_d <= done;
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         summarize();
      end
   end

   initial
   begin
      repeat (4) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      rd_reg(OFS_OAR, OAR_RST);
      rd_reg(OFS_CTL, CTL_RST);
      rd_reg(OFS_STS, ST_NONE);
      rd_reg(OFS_DAT, DAT_RST);
      seed = xs(seed);
      own = (seed[6:0] == 7'h00) ? 7'h2A : seed[6:0];
      gce = 1'b1;
      ctl_ack = 1'b1;
      wr_reg(OFS_OAR, {own, 1'b1});
      rd_reg(OFS_OAR, {own, 1'b1});
      wr_reg(OFS_CTL, 8'h45);
      wr_reg(OFS_DAT, 8'h5A);
      rd_reg(OFS_CTL, 8'h4D);
      rd_reg(OFS_DAT, DAT_RST);
      for (int i = 0; i < 8; i++)
         frame({own, 1'b0}, i[0], i[1], i[2]);
      for (int i = 0; i < 4; i++)
         frame(GC_ADDR, i[0], i[1], 1'b0);
      frame({own, 1'b1}, 1'b0, 1'b1, 1'b0);
      frame({own ^ 7'h15, 1'b0}, 1'b0, 1'b1, 1'b0);
      gce = 1'b0;
      wr_reg(OFS_OAR, {own, 1'b0});
      frame(GC_ADDR, 1'b0, 1'b1, 1'b0);
      ctl_ack = 1'b0;
      wr_reg(OFS_CTL, 8'h05);
      frame({own, 1'b0}, 1'b0, 1'b1, 1'b0);
      ctl_ack = 1'b1;
      wr_reg(OFS_CTL, 8'h45);
      frame({own, 1'b0}, 1'b0, 1'b1, 1'b0);
      summarize();
   end
endmodule : two_wire_slave_receiver_test
